// [common/fic_pkg.sv]
package fic_pkg;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned CFG_WORDS = 4;
    localparam int unsigned PROG_BYTES = 524288;
    localparam int unsigned BOOT_BYTES = 12288;
    localparam int unsigned CFG_BYTES = 16;
    localparam logic [31:0] PROG_BASE = 32'h1d000000;
    localparam logic [31:0] BOOT_BASE = 32'h1fc00000;
    localparam logic [31:0] CFG0_MASK = 32'h110ff00b;
    localparam logic [31:0] CFG1_MASK = 32'h009ff7a7;
    localparam logic [31:0] CFG2_MASK = 32'h00070077;
    localparam logic [31:0] CFG3_MASK = 32'h00000000;
    localparam logic [31:0] ID_MASK = 32'h000ff000;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    localparam int unsigned CODE_PROTECT_POS = 28;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_RESULT = 3'h2;
    localparam logic [2:0] REG_PROG_SUM = 3'h3;
    localparam logic [2:0] REG_BOOT_SUM = 3'h4;
    localparam logic [2:0] REG_CFG_SUM = 3'h5;
    localparam logic [2:0] REG_ID_SUM = 3'h6;

    typedef struct packed {
        logic [2:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fic_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic word;
    } fic_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } fic_mem_rsp_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_PROG = 6'b000010,
        ST_BOOT = 6'b000100,
        ST_CFG = 6'b001000,
        ST_ID = 6'b010000,
        ST_DONE = 6'b100000
    } fic_state_t;
endpackage

// [core/fic_byte_adder.sv]
`timescale 1ns/10ps
module fic_byte_adder (
    input wire logic [31:0] word,
    input wire logic [31:0] mask,
    output logic [9:0] sum
);
    import fic_pkg::*;
    wire [31:0] masked = word & mask;
    assign sum = {2'h0, masked[7:0]} + {2'h0, masked[15:8]} + {2'h0, masked[23:16]} + {2'h0, masked[31:24]};
endmodule

// [core/fic_engine.sv]
`timescale 1ns/10ps
module fic_engine #(
    parameter int unsigned PROG_LEN = fic_pkg::PROG_BYTES,
    parameter int unsigned BOOT_LEN = fic_pkg::BOOT_BYTES,
    parameter logic [31:0] PROG_ADDR = fic_pkg::PROG_BASE,
    parameter logic [31:0] BOOT_ADDR = fic_pkg::BOOT_BASE,
    parameter logic [127:0] CFG_MASKS = {fic_pkg::CFG3_MASK, fic_pkg::CFG2_MASK, fic_pkg::CFG1_MASK,
        fic_pkg::CFG0_MASK},
    parameter logic [31:0] IDENT_MASK = fic_pkg::ID_MASK
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire fic_pkg::fic_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    output fic_pkg::fic_mem_req_t mem_req,
    input wire fic_pkg::fic_mem_rsp_t mem_rsp,
    input wire logic [31:0] part_identifier_register,
    input wire logic start,
    output logic done,
    output logic [31:0] result
);
    import fic_pkg::*;

    fic_state_t state;
    fic_state_t next_state;
    logic [31:0] offset;
    logic [1:0] cfg_index;
    logic pending;
    logic [31:0] program_area_sum;
    logic [31:0] boot_area_sum;
    logic [31:0] masked_config_sum;
    logic [31:0] id_sum;
    logic code_protected;
    logic sw_start;
    logic [31:0] rdata_next;

    localparam int unsigned BOOT_PLAIN = BOOT_LEN - CFG_BYTES;

    wire go = (start | sw_start) & (state == ST_IDLE || state == ST_DONE);
    wire rsp = pending & mem_rsp.valid;
    wire [31:0] cfg_mask = CFG_MASKS[32 * cfg_index +: 32];
    wire [31:0] word_mask = (state == ST_ID) ? IDENT_MASK : cfg_mask;
    wire [31:0] word_in = (state == ST_ID) ? part_identifier_register : mem_rsp.data;
    wire [9:0] word_sum;
    wire [31:0] total = program_area_sum + boot_area_sum + masked_config_sum + id_sum;
    wire [31:0] cfg_addr = BOOT_ADDR + 32'(BOOT_LEN) - 32'h00000004 - {28'h0, cfg_index, 2'h0};
    wire last_prog = offset == 32'(PROG_LEN - 1);
    wire last_boot = offset == 32'(BOOT_PLAIN - 1);
    wire cp_seen = (state == ST_CFG) && (cfg_index == 2'h0) && !mem_rsp.data[CODE_PROTECT_POS];

    fic_byte_adder u_adder (
        .word(word_in),
        .mask(word_mask),
        .sum(word_sum)
    );

    // Requests go out one at a time; a response closes each before the next, so the read path may stall freely.
    assign mem_req.valid = pending;
    assign mem_req.word = (state == ST_CFG);
    assign mem_req.addr = (state == ST_PROG) ? PROG_ADDR + offset :
                          (state == ST_BOOT) ? BOOT_ADDR + offset : cfg_addr;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (go) next_state = ST_PROG;
            ST_PROG: if (rsp && last_prog) next_state = ST_BOOT;
            ST_BOOT: if (rsp && last_boot) next_state = ST_CFG;
            ST_CFG: if (rsp && cfg_index == 2'h3) next_state = ST_ID;
            ST_ID: next_state = ST_DONE;
            ST_DONE: if (go) next_state = ST_PROG;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || go) begin
            offset <= 32'h0;
            cfg_index <= 2'h0;
            pending <= go;
        end else if (rsp) begin
            offset <= (last_prog && state == ST_PROG) ? 32'h0 : offset + 32'h1;
            cfg_index <= (state == ST_CFG) ? cfg_index + 2'h1 : cfg_index;
            pending <= !(state == ST_CFG && cfg_index == 2'h3);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || go) begin
            program_area_sum <= 32'h0;
            boot_area_sum <= 32'h0;
            masked_config_sum <= 32'h0;
            id_sum <= 32'h0;
            code_protected <= 1'b0;
        end else begin
            if (rsp && state == ST_PROG) program_area_sum <= program_area_sum + {24'h0, mem_rsp.data[7:0]};
            if (rsp && state == ST_BOOT) boot_area_sum <= boot_area_sum + {24'h0, mem_rsp.data[7:0]};
            if (rsp && state == ST_CFG) masked_config_sum <= masked_config_sum + {22'h0, word_sum};
            if (rsp && cp_seen) code_protected <= 1'b1;
            if (state == ST_ID) id_sum <= {22'h0, word_sum};
        end
    end

    // Code protection is the active-low protect bit of configuration word 0, a cleared bit means protected.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result <= RESULT_RESET;
            done <= 1'b0;
        end else if (go) begin
            done <= 1'b0;
        end else if (state == ST_ID) begin
            result <= code_protected ? 32'h0 : ~(total + {22'h0, word_sum}) + 32'h1;
            done <= 1'b1;
        end
    end

    assign sw_start = reg_req.wr && reg_req.addr == REG_CTRL && reg_req.wdata[0];

    always_comb begin
        unique case (reg_req.addr)
            REG_STATUS: rdata_next = {29'h0, code_protected, state != ST_IDLE && state != ST_DONE, done};
            REG_RESULT: rdata_next = result;
            REG_PROG_SUM: rdata_next = program_area_sum;
            REG_BOOT_SUM: rdata_next = boot_area_sum;
            REG_CFG_SUM: rdata_next = masked_config_sum;
            REG_ID_SUM: rdata_next = id_sum;
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_req.rd ? rdata_next : 32'h0;
        end
    end
endmodule

// [verif/fic_props.sv]
`timescale 1ns/10ps
module fic_props #(
    parameter int unsigned PROG_LEN = 8,
    parameter int unsigned BOOT_LEN = 20
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire fic_pkg::fic_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire fic_pkg::fic_mem_req_t mem_req,
    input wire fic_pkg::fic_mem_rsp_t mem_rsp,
    input wire logic start,
    input wire logic done,
    input wire logic [31:0] result
);
    import fic_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [31:0] cfg_lo = BOOT_BASE + BOOT_LEN - 16;
    wire in_boot = mem_req.addr >= BOOT_BASE;
    a_request_held: assert property (mem_req.valid && !mem_rsp.valid |=> mem_req.valid && $stable(mem_req.addr))
        else $error("request changed before reply");
    a_prog_bytes: assert property (mem_req.valid && !in_boot |-> !mem_req.word && mem_req.addr < PROG_BASE + PROG_LEN)
        else $error("bad program read");
    a_boot_bytes: assert property (mem_req.valid && in_boot && !mem_req.word |-> mem_req.addr < cfg_lo)
        else $error("byte read inside config words");
    a_cfg_words: assert property (mem_req.valid && mem_req.word |-> in_boot && mem_req.addr >= cfg_lo)
        else $error("config word read outside its area");
    a_done_holds: assert property (done && !start && !reg_req.wr |=> done && $stable(result))
        else $error("done or result moved");
    a_idle_done: assert property (done |-> !mem_req.valid)
        else $error("read while done");
    a_restart_first: assert property (done && start |=> !done && mem_req.valid && mem_req.addr == PROG_BASE)
        else $error("restart did not read first byte");
    a_result_read: assert property (reg_req.rd && reg_req.addr == REG_RESULT |=> reg_rdata == $past(result))
        else $error("result register mismatch");
    c_restart: cover property (done && start);
    c_word_read: cover property (mem_req.valid && mem_req.word && mem_rsp.valid);
    c_result_read: cover property (reg_req.rd && reg_req.addr == REG_RESULT);
endmodule

// [verif/fic_mem_model.sv]
`timescale 1ns/10ps
module fic_mem_model (
    input wire logic clock,
    input wire fic_pkg::fic_mem_req_t mem_req,
    input wire logic [31:0] cfg0,
    output fic_pkg::fic_mem_rsp_t mem_rsp
);
    import fic_pkg::*;
    logic [1:0] waited = 2'h0;
    wire [31:0] word_val = (mem_req.addr[4:2] == 3'h4) ? cfg0 : 32'hffffffff;
    wire [7:0] byte_val = mem_req.addr[7:0] + 8'h31;
    initial mem_rsp = '0;
    // Reply delay varies with the address, and idle data toggles so stale values never look valid.
    always @(posedge clock) begin
        mem_rsp.valid <= 1'b0;
        mem_rsp.data <= ~mem_rsp.data;
        if (mem_req.valid && !mem_rsp.valid) begin
            waited <= (waited == mem_req.addr[1:0]) ? 2'h0 : waited + 2'h1;
            if (waited == mem_req.addr[1:0]) begin
                mem_rsp.valid <= 1'b1;
                mem_rsp.data <= mem_req.word ? word_val : {~byte_val, ~byte_val, ~byte_val, byte_val};
            end
        end
    end
endmodule

// [verif/flash_image_checksum_tb_top.sv]
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module flash_image_checksum_tb_top;
    import fic_pkg::*;
    typedef struct packed {
        logic [31:0] cfg0;
        logic [31:0] ident;
        logic use_reg;
    } fic_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic done;
    logic [31:0] ident = 32'h0;
    logic [31:0] cfg0 = 32'h0;
    logic [31:0] rdat;
    logic [31:0] reg_rdata;
    logic [31:0] result;
    fic_reg_req_t reg_req = '0;
    fic_mem_req_t mem_req;
    fic_mem_rsp_t mem_rsp;
    int mismatches = 0;
    int checks_done = 0;
    fic_row_t rows [3] = '{'{32'h7fffffff, 32'h00938053, 1'b0}, '{32'hffffffff, 32'hffffffff, 1'b1},
        '{32'hefffffff, 32'h00938053, 1'b0}};
    fic_engine #(.PROG_LEN(8), .BOOT_LEN(20)) fic_engine_i (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .part_identifier_register(ident),
        .start(start), .done(done), .result(result));
    fic_mem_model fic_mem_model_i (.clock(clock), .mem_req(mem_req), .cfg0(cfg0), .mem_rsp(mem_rsp));
    function automatic logic [31:0] bsum(input logic [31:0] w);
        return w[7:0] + w[15:8] + w[23:16] + w[31:24];
    endfunction
    function automatic logic [31:0] expect_sum(input fic_row_t r);
        logic [31:0] t;
        t = bsum(r.cfg0 & CFG0_MASK) + bsum(CFG1_MASK) + bsum(CFG2_MASK) + bsum(CFG3_MASK) + bsum(r.ident & ID_MASK);
        for (int a = 0; a < 8; a++) t += a + 8'h31;
        for (int a = 0; a < 4; a++) t += a + 8'h31;
        return r.cfg0[CODE_PROTECT_POS] ? -t : 32'h0;
    endfunction
    task automatic reg_read(input logic [2:0] a);
        @(posedge clock);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
        @(negedge clock);
        rdat = reg_rdata;
    endtask
    task automatic run(input fic_row_t r);
        int n;
        @(posedge clock);
        cfg0 <= r.cfg0;
        ident <= r.ident;
        @(posedge clock);
        if (r.use_reg) reg_req <= '{REG_CTRL, 32'h1, 1'b1, 1'b0};
        else start <= 1'b1;
        @(posedge clock);
        reg_req.wr <= 1'b0;
        start <= 1'b0;
        repeat (3) @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        @(negedge clock);
        `CHK("result", expect_sum(r), result)
        reg_read(REG_RESULT);
        `CHK("result_reg", expect_sum(r), rdat)
        reg_read(REG_STATUS);
        `CHK("status", {29'h0, ~r.cfg0[CODE_PROTECT_POS], 2'b01}, rdat)
        reg_read(REG_PROG_SUM);
        `CHK("prog_sum", 32'h000001a4, rdat)
        reg_read(REG_BOOT_SUM);
        `CHK("boot_sum", 32'h000000ca, rdat)
        reg_read(REG_CFG_SUM);
        `CHK("cfg_sum", bsum(r.cfg0 & CFG0_MASK) + bsum(CFG1_MASK) + bsum(CFG2_MASK) + bsum(CFG3_MASK), rdat)
        reg_read(REG_ID_SUM);
        `CHK("id_sum", bsum(r.ident & ID_MASK), rdat)
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial forever #12.5 clock = ~clock;
    initial begin
        #100000;
        mismatches++;
        results();
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        reg_read(3'h7);
        `CHK("unmapped", 32'h0, rdat)
        foreach (rows[i]) run(rows[i]);
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        `CHK("reset", 34'h0, {done, mem_req.valid, result})
        run(rows[0]);
        results();
    end
endmodule
bind fic_engine fic_props #(.PROG_LEN(PROG_LEN), .BOOT_LEN(BOOT_LEN)) fic_props_i (.clock(clock), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .start(start), .done(done),
    .result(result));
